// >>> rtl/rwf_filter.sv
// Receive wake-frame filter: register file, frame matchers, event flags,
// interrupt and wake output.
// Assumes a received byte stream on the same clock, marked by valid, start
// and end strobes, with CRC and delimiter errors reported by the receiver.
// Assumes single-cycle register strobes, never both high at once; a clock
// enable held low freezes every flop and drops accesses.
//
// Notes on behaviour
// - Level style: writing the level-clear bit drops the latched wake output.
// - Pulse width field selects 8, 16, 32 or 64 clock cycles.
// - Style bit: 0 gives a pulse, 1 holds a level until cleared.
// - Enhanced receive enable gates wake detection and CRC checking.
// - Unicast enable: frame to programmed address raises an event.
// - Broadcast enable: broadcast frame raises an event.
// - Pattern enable: frame matching masked byte pattern raises an event.
// - Magic enable: valid magic frame raises an event.
// - Match flags at bits 4,2,1,0, set on detect, cleared by reading.
// - Delimiter error bit 7, bad CRC bit 6, cleared by reading.
// - Three words form the 48-bit destination address, low word first.
// - Three words form the 48-bit password, low word first.
// - Pattern held two bytes per word, byte 0 low; bytes maskable.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module rwf_filter (
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Register port
   input wire logic [8:0] addr_in,
   input wire logic [15:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [15:0] rd_data_out,
   // Received frame stream
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_sof_in,
   input wire logic rx_eof_in,
   input wire logic rx_crc_err_in,
   input wire logic rx_delimiter_error_flag_in,
   // Wake and interrupt
   output logic wake_output_out,
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // Register map, 16-bit words
   //   0x134 configuration: 11 level clear (write pulse), 10:9 pulse
   //         width, 8 output style, 7 enhanced receive enable,
   //         4 unicast, 2 broadcast, 1 pattern, 0 magic enables
   //   0x135 event flags, cleared by reading, writes ignored
   //   0x136..0x138 destination address, low word first
   //   0x139..0x13b magic password, low word first
   //   0x13c pattern bytes 1:0, byte 0 in the low half
   //   0x150 pattern byte mask, bit i set ignores byte i
   //   0x151 interrupt status, sticky, read only
   //   0x152 interrupt clear, write ones, reads zero
   //   0x153 interrupt enable, same layout as the flags
   // Reserved configuration bits are stored and read back.
   // Every other offset reads zero and ignores writes.
   //
   // Frame timing at the ports
   //   One byte per valid strobe; the start mark sits on byte 0.
   //   The end mark comes in a cycle of its own after the last
   //   byte, with the receiver's CRC verdict beside it.
   //   Flags, interrupt status, interrupt and wake all change at
   //   the end-mark edge and show one cycle later.
   //   An end mark with no start before it is ignored, so a frame
   //   cut short by a link drop raises nothing.
   // Limitation: only two pattern bytes are held here; longer
   // patterns need more pattern words and mask bits.

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      // Software-visible registers
      logic [15:0] cfg;
      logic [15:0] flags;
      logic [47:0] da;
      logic [47:0] pw;
      logic [15:0] pat;
      logic [1:0] pmask;
      logic [15:0] irq_st;
      logic [15:0] irq_en;
      // Bus and output flops
      logic [15:0] rd_data;
      logic irq;
      logic wake;
      logic [6:0] wcnt;
      // Frame position and match tracking
      logic in_frame;
      logic [2:0] bidx;
      logic da_eq;
      logic bc_eq;
      logic pat_eq;
      // Magic frame scanner
      logic [2:0] mg_sync;
      logic [4:0] mg_rep;
      logic [2:0] mg_pos;
      logic mg_pw;
      logic mg_done;
   } rwf_state_s;

   // Current and next copy of all state
   rwf_state_s st;
   rwf_state_s next_st;

   ////////////////////////////////////////////////////////////////////////
   // per-byte pattern compare; a masked byte always agrees
   logic [1:0] pat_byte_ok;
   genvar gi;

   generate
      for (gi = 0; gi < 2; gi++) begin : g_pat
         assign pat_byte_ok[gi] = st.pmask[gi] || (rx_data_in == st.pat[8 * gi +: 8]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole block
   always_comb begin
      logic [15:0] ev;
      logic [2:0] idx;
      logic [7:0] exp_b;
      logic good;
      logic enh;
      logic style_level;
      next_st = st;
      ev = 16'h0000;
      idx = 3'h0;
      exp_b = 8'h00;
      good = 1'b0;
      enh = st.cfg[rwf_pkg::CFG_ENH];
      style_level = st.cfg[rwf_pkg::CFG_STYLE];
      next_st.rd_data = 16'h0000;

      // Matchers start optimistic at the start byte and are knocked
      // out by the first byte that disagrees; counting bytes keeps a
      // short frame from matching on a partial address.
      // Byte stream: start of frame restarts every matcher
      if (rx_valid_in) begin
         if (rx_sof_in) begin
            next_st.in_frame = 1'b1;
            next_st.bidx = 3'h0;
            next_st.da_eq = 1'b1;
            next_st.bc_eq = 1'b1;
            next_st.pat_eq = 1'b1;
            next_st.mg_sync = 3'h0;
            next_st.mg_rep = 5'h00;
            next_st.mg_pos = 3'h0;
            next_st.mg_pw = 1'b0;
            next_st.mg_done = 1'b0;
         end
         idx = next_st.bidx;
         if (next_st.in_frame) begin
            // destination address compare, first byte against bits 7:0
            if (idx < rwf_pkg::ADDR_BYTES) begin
               if (rx_data_in != st.da[{idx, 3'h0} +: 8]) begin
                  next_st.da_eq = 1'b0;
               end
               if (rx_data_in != rwf_pkg::ALL_ONES) begin
                  next_st.bc_eq = 1'b0;
               end
            end
            // masked pattern compare, byte 0 in the low byte
            if (idx < rwf_pkg::PAT_BYTES) begin
               if (!pat_byte_ok[idx[0]]) begin
                  next_st.pat_eq = 1'b0;
               end
            end
            // Nothing past the address needs a finer position
            // Saturate so long frames keep the count at its top
            if (idx != 3'h7) begin
               next_st.bidx = idx + 3'h1;
            end
            // The scanner counts sync bytes first, then walks the
            // address copies: mg_pos is the byte within a copy, mg_rep
            // the copy number, mg_pw marks the password tail.
            // Any mismatch but an extra 0xff before the first copy drops back to hunting for sync, so the
            // sequence may start anywhere in the frame.
            // magic frame scanner
            if (!next_st.mg_done) begin
               if (next_st.mg_sync < rwf_pkg::SYNC_BYTES) begin
                  if (rx_data_in == rwf_pkg::ALL_ONES) begin
                     next_st.mg_sync = next_st.mg_sync + 3'h1;
                  end else begin
                     next_st.mg_sync = 3'h0;
                  end
               end else begin
                  // password bytes follow the address copies
                  if (next_st.mg_pw) begin
                     exp_b = st.pw[{next_st.mg_pos, 3'h0} +: 8];
                  end else begin
                     exp_b = st.da[{next_st.mg_pos, 3'h0} +: 8];
                  end
                  if (rx_data_in == exp_b) begin
                     if (next_st.mg_pos == rwf_pkg::ADDR_BYTES - 3'h1) begin
                        next_st.mg_pos = 3'h0;
                        if (next_st.mg_pw) begin
                           next_st.mg_done = 1'b1;
                        end else if (next_st.mg_rep == rwf_pkg::ADDR_REPS - 5'h01) begin
                           // Zero password means no password check
                           if (st.pw == 48'h0) begin
                              next_st.mg_done = 1'b1;
                           end else begin
                              next_st.mg_pw = 1'b1;
                           end
                        end else begin
                           next_st.mg_rep = next_st.mg_rep + 5'h01;
                        end
                     end else begin
                        next_st.mg_pos = next_st.mg_pos + 3'h1;
                     end
                  end else begin
                     // Extra 0xff before the first copy keeps sync
                     if (rx_data_in == rwf_pkg::ALL_ONES) begin
                        if (next_st.mg_rep == 5'h00 && next_st.mg_pos == 3'h0 &&
                            !next_st.mg_pw) begin
                           next_st.mg_sync = rwf_pkg::SYNC_BYTES;
                        end else begin
                           next_st.mg_sync = 3'h1;
                        end
                     end else begin
                        next_st.mg_sync = 3'h0;
                     end
                     next_st.mg_rep = 5'h00;
                     next_st.mg_pos = 3'h0;
                     next_st.mg_pw = 1'b0;
                  end
               end
            end
         end
      end

      // CRC errors are flagged even when no wake source is enabled;
      // matches need the whole address, or both pattern bytes, to
      // have been seen before the end mark.
      // End of frame: matches count only for frames with a good CRC
      if (rx_eof_in && st.in_frame) begin
         next_st.in_frame = 1'b0;
         good = !rx_crc_err_in;
         if (enh) begin
            ev[rwf_pkg::FLG_CRC] = rx_crc_err_in;
            ev[rwf_pkg::FLG_UCAST] = good && st.cfg[rwf_pkg::CFG_UCAST] &&
                                     st.da_eq && st.bidx >= rwf_pkg::ADDR_BYTES;
            ev[rwf_pkg::FLG_BCAST] = good && st.cfg[rwf_pkg::CFG_BCAST] &&
                                     st.bc_eq && st.bidx >= rwf_pkg::ADDR_BYTES;
            // pattern wake, needs one unmasked byte
            ev[rwf_pkg::FLG_PAT] = good && st.cfg[rwf_pkg::CFG_PAT] && st.pat_eq &&
                                   st.bidx >= rwf_pkg::PAT_BYTES && st.pmask != 2'h3;
            ev[rwf_pkg::FLG_MAGIC] = good && st.cfg[rwf_pkg::CFG_MAGIC] && st.mg_done;
         end
      end
      // Delimiter errors arrive outside frames and need no frame
      // context; only the enhanced enable gates them.
      // delimiter error event
      ev[rwf_pkg::FLG_SFD] = enh && rx_delimiter_error_flag_in;

      // Read data is registered and falls back to zero the cycle
      // after, so a stale word never lingers on the bus and the
      // master needs no wait.
      // Register reads; unmapped offsets answer zero
      if (rd_en_in) begin
         case (addr_in)
            rwf_pkg::OFS_CFG: next_st.rd_data = st.cfg;
            rwf_pkg::OFS_FLAGS: next_st.rd_data = st.flags;
            rwf_pkg::OFS_DA0: next_st.rd_data = st.da[15:0];
            rwf_pkg::OFS_DA1: next_st.rd_data = st.da[31:16];
            rwf_pkg::OFS_DA2: next_st.rd_data = st.da[47:32];
            rwf_pkg::OFS_PW0: next_st.rd_data = st.pw[15:0];
            rwf_pkg::OFS_PW1: next_st.rd_data = st.pw[31:16];
            rwf_pkg::OFS_PW2: next_st.rd_data = st.pw[47:32];
            rwf_pkg::OFS_PAT0: next_st.rd_data = st.pat;
            rwf_pkg::OFS_PMASK: next_st.rd_data = {14'h0000, st.pmask};
            rwf_pkg::OFS_IRQ_STAT: next_st.rd_data = st.irq_st;
            rwf_pkg::OFS_IRQ_EN: next_st.rd_data = st.irq_en;
            default: next_st.rd_data = 16'h0000;
         endcase
      end

      // A read returns the flags as they stood before the edge; an
      // event at that edge shows up on the next read instead.
      // read clears flags, a new event in the same cycle wins
      if (rd_en_in && addr_in == rwf_pkg::OFS_FLAGS) begin
         next_st.flags = 16'h0000;
      end
      next_st.flags = next_st.flags | (ev & rwf_pkg::FLG_MASK);

      // Writes land at the strobe edge; reserved configuration bits
      // are kept so software reads back what it wrote, all but the
      // clear bit, which is only a pulse.
      // Register writes; the flag register ignores writes
      if (wr_en_in) begin
         case (addr_in)
            // Clear bit is a write pulse and is never stored
            rwf_pkg::OFS_CFG: next_st.cfg = wr_data_in & rwf_pkg::CFG_STORE_MASK;
            rwf_pkg::OFS_DA0: next_st.da[15:0] = wr_data_in;
            rwf_pkg::OFS_DA1: next_st.da[31:16] = wr_data_in;
            rwf_pkg::OFS_DA2: next_st.da[47:32] = wr_data_in;
            rwf_pkg::OFS_PW0: next_st.pw[15:0] = wr_data_in;
            rwf_pkg::OFS_PW1: next_st.pw[31:16] = wr_data_in;
            rwf_pkg::OFS_PW2: next_st.pw[47:32] = wr_data_in;
            rwf_pkg::OFS_PAT0: next_st.pat = wr_data_in;
            rwf_pkg::OFS_PMASK: next_st.pmask = wr_data_in[1:0];
            rwf_pkg::OFS_IRQ_CLR: next_st.irq_st = st.irq_st & ~wr_data_in;
            rwf_pkg::OFS_IRQ_EN: next_st.irq_en = wr_data_in & rwf_pkg::FLG_MASK;
            default: next_st.irq_en = next_st.irq_en;
         endcase
      end
      // The interrupt follows the next status and enable, so it
      // rises at the same edge as the status bit and drops at the
      // clear edge rather than a cycle later.
      // Sticky interrupt status; set wins over a clear write
      next_st.irq_st = next_st.irq_st | (ev & rwf_pkg::FLG_MASK);
      next_st.irq = |(next_st.irq_st & next_st.irq_en);

      // Pulse style loads the count at the event and drops the pin
      // when it reaches zero, so the pin is high exactly the chosen
      // number of cycles. A new event during a pulse reloads the
      // count and stretches it.
      // Level style ignores the count and waits for the clear write;
      // an event in the same cycle as the clear keeps the pin high.
      // Wake output: a level stays until cleared, a pulse counts down
      if (st.wake && !style_level) begin
         if (st.wcnt == 7'h00) begin
            next_st.wake = 1'b0;
         end else begin
            next_st.wcnt = st.wcnt - 7'h01;
         end
      end
      // level clear by write to the clear bit
      if (wr_en_in && addr_in == rwf_pkg::OFS_CFG && wr_data_in[rwf_pkg::CFG_LEVEL_CLR] &&
          style_level) begin
         next_st.wake = 1'b0;
      end
      // a wake event starts the pulse or sets the level
      if (|(ev & rwf_pkg::FLG_WAKE_MASK)) begin
         next_st.wake = 1'b1;
         // width is base count shifted by the select field
         next_st.wcnt = (rwf_pkg::PULSE_BASE_CYC << st.cfg[rwf_pkg::CFG_WIDTH_LO +: 2])
                        - 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset loads constants only; the configuration reset value
   // keeps every wake source off and the wake pin low, and no
   // clock is needed while reset is held.
   // State register; clock enable low freezes everything
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st <= '0;
         st.cfg <= rwf_pkg::CFG_RESET;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   // No logic after the flops, so the pins never glitch
   // Outputs straight from the state flops
   assign rd_data_out = st.rd_data;
   assign wake_output_out = st.wake;
   assign irq_out = st.irq;

endmodule

// >>> rtl/rwf_pkg.sv
// Constants for the receive wake-frame filter: register offsets, field
// positions, reset values and timing counts.
// Assumes a 9-bit register address and 16-bit register data.
package rwf_pkg;
   // Widths
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   // Register offsets
   localparam logic [8:0] OFS_CFG = 9'h134;
   localparam logic [8:0] OFS_FLAGS = 9'h135;
   localparam logic [8:0] OFS_DA0 = 9'h136;
   localparam logic [8:0] OFS_DA1 = 9'h137;
   localparam logic [8:0] OFS_DA2 = 9'h138;
   localparam logic [8:0] OFS_PW0 = 9'h139;
   localparam logic [8:0] OFS_PW1 = 9'h13a;
   localparam logic [8:0] OFS_PW2 = 9'h13b;
   localparam logic [8:0] OFS_PAT0 = 9'h13c;
   localparam logic [8:0] OFS_PMASK = 9'h150;
   localparam logic [8:0] OFS_IRQ_STAT = 9'h151;
   localparam logic [8:0] OFS_IRQ_CLR = 9'h152;
   localparam logic [8:0] OFS_IRQ_EN = 9'h153;
   // Configuration fields
   localparam int CFG_LEVEL_CLR = 11;
   localparam int CFG_WIDTH_LO = 9;
   localparam int CFG_STYLE = 8;
   localparam int CFG_ENH = 7;
   localparam int CFG_UCAST = 4;
   localparam int CFG_BCAST = 2;
   localparam int CFG_PAT = 1;
   localparam int CFG_MAGIC = 0;
   localparam logic [15:0] CFG_RESET = 16'h1000;
   localparam logic [15:0] CFG_STORE_MASK = 16'hf7ff;
   // Event flag positions
   localparam int FLG_SFD = 7;
   localparam int FLG_CRC = 6;
   localparam int FLG_UCAST = 4;
   localparam int FLG_BCAST = 2;
   localparam int FLG_PAT = 1;
   localparam int FLG_MAGIC = 0;
   localparam logic [15:0] FLG_MASK = 16'h00d7;
   localparam logic [15:0] FLG_WAKE_MASK = 16'h0017;
   // Timing and frame figures
   localparam logic [6:0] PULSE_BASE_CYC = 7'h08;
   localparam logic [2:0] ADDR_BYTES = 3'h6;
   localparam logic [2:0] SYNC_BYTES = 3'h6;
   localparam logic [4:0] ADDR_REPS = 5'h10;
   localparam logic [2:0] PAT_BYTES = 3'h2;
   localparam logic [7:0] ALL_ONES = 8'hff;
endpackage

// >>> test/rwf_filter_sva.sv
// Port-level assertions for the receive wake-frame filter.
// Assumes a single clock domain; bound to every filter instance below.
`timescale 1ns/1ps
module rwf_filter_sva (
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Register port
   input wire logic [8:0] addr_in,
   input wire logic [15:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [15:0] rd_data_out,
   // Frame, wake, interrupt
   input wire logic rx_eof_in,
   input wire logic rx_delimiter_error_flag_in,
   input wire logic wake_output_out,
   input wire logic irq_out
);
   logic [15:0] cfg_sh;
   logic [15:0] ien_sh;
   logic [7:0] hi_cnt;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   ////////////////////////////////////////////////////////////////////////
   // Shadows of written controls; a restarted pulse would need its own count
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cfg_sh <= 16'h1000;
         ien_sh <= 16'h0000;
         hi_cnt <= 8'h00;
      end else begin
         hi_cnt <= wake_output_out ? hi_cnt + 8'h01 : 8'h00;
         if (wr_en_in && ce_in && addr_in == 9'h134) begin
            cfg_sh <= wr_data_in;
         end
         if (wr_en_in && ce_in && addr_in == 9'h153) begin
            ien_sh <= wr_data_in & 16'h00d7;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   rd_idle_a: assert property (
      !$past(rd_en_in & ce_in) |-> rd_data_out == 16'h0000) else $error("read data not idle");
   unmapped_rd_a: assert property (
      rd_en_in && ce_in && (addr_in < 9'h134 || addr_in > 9'h153 || addr_in == 9'h152 ||
      (addr_in > 9'h13c && addr_in < 9'h150)) |=> rd_data_out == 16'h0000)
      else $error("unmapped read not zero");
   flag_rsvd_a: assert property (
      rd_en_in && ce_in && addr_in == 9'h135 |=> (rd_data_out & 16'hff28) == 16'h0000)
      else $error("reserved flag bit set");
   clear_bit_a: assert property (
      rd_en_in && ce_in && addr_in == 9'h134 |=> !rd_data_out[11]) else $error("bit 11 read");
   rc_clear_a: assert property (
      rd_en_in && ce_in && addr_in == 9'h135 && !rx_eof_in && !rx_delimiter_error_flag_in ##1
      rd_en_in && ce_in && addr_in == 9'h135 && !rx_eof_in && !rx_delimiter_error_flag_in
      |=> rd_data_out == 16'h0000) else $error("flags survive read");
   wake_cause_a: assert property (
      $rose(wake_output_out) |-> $past(rx_eof_in)) else $error("wake without frame end");
   pulse_len_a: assert property (
      $fell(wake_output_out) && !cfg_sh[8] |-> hi_cnt == (8'h08 << cfg_sh[10:9]))
      else $error("pulse length wrong");
   level_clr_a: assert property (
      wr_en_in && ce_in && addr_in == 9'h134 && wr_data_in[11] && wr_data_in[8] && cfg_sh[8]
      && !rx_eof_in |=> !wake_output_out) else $error("level wake not cleared");
   irq_gate_a: assert property (
      irq_out |-> ien_sh != 16'h0000) else $error("interrupt while disabled");
   enh_gate_a: assert property (
      rx_eof_in && !cfg_sh[7] |=> !$rose(wake_output_out)) else $error("wake while disabled");
endmodule
bind rwf_filter rwf_filter_sva chk_i (.clk_in, .rstn_in, .ce_in, .addr_in, .wr_data_in,
   .wr_en_in, .rd_en_in, .rd_data_out, .rx_eof_in, .rx_delimiter_error_flag_in, .wake_output_out, .irq_out);

// >>> test/rwf_station.sv
// Remote station model: sends received bytes with start and end marks.
// Assumes the caller waits for each task to return before the next.
`timescale 1ns/1ps
module rwf_station (
   // Clock
   input wire logic clk_in,
   // Received stream towards the filter
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic rx_sof_out,
   output logic rx_eof_out,
   output logic rx_crc_err_out,
   output logic rx_delimiter_error_flag_out
);
   // Idle line levels at time zero
   initial begin
      {rx_valid_out, rx_sof_out, rx_eof_out, rx_crc_err_out, rx_delimiter_error_flag_out} = 5'h00;
      rx_data_out = 8'h00;
   end
   // One frame; data and error line inverted when not qualified
   task automatic send(input logic [7:0] q[$], input logic bad);
      for (int i = 0; i < q.size(); i++) begin
         @(posedge clk_in);
         rx_valid_out <= 1'b1;
         rx_sof_out <= (i == 0);
         rx_data_out <= q[i];
      end
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_sof_out <= 1'b0;
      rx_data_out <= ~q[q.size() - 1];
      rx_eof_out <= 1'b1;
      rx_crc_err_out <= bad;
      @(posedge clk_in);
      rx_eof_out <= 1'b0;
      rx_crc_err_out <= ~bad;
   endtask
   // Single-cycle delimiter error
   task automatic sfd();
      @(posedge clk_in);
      rx_delimiter_error_flag_out <= 1'b1;
      @(posedge clk_in);
      rx_delimiter_error_flag_out <= 1'b0;
   endtask
endmodule

// >>> test/rwf_filter_tb.sv
// Testbench for the wake-frame filter: register tasks, frames, checks.
// Assumes the design, checker and station model are compiled first.
`timescale 1ns/1ps
module rwf_filter_tb;
   typedef logic [7:0] rwf_bq_t[$];
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [8:0] addr = 9'h000;
   logic [15:0] wdata = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [15:0] rd_data;
   logic [7:0] rx_data;
   logic rx_valid, rx_sof, rx_eof, rx_crc, rx_sfd, wake, irq;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   rwf_bq_t uc = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00, 8'h01};
   rwf_bq_t mg = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
   always #2.5 clk_in = ~clk_in;
   rwf_filter uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .addr_in(addr),
      .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
      .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_sof_in(rx_sof), .rx_eof_in(rx_eof),
      .rx_crc_err_in(rx_crc), .rx_delimiter_error_flag_in(rx_sfd), .wake_output_out(wake), .irq_out(irq));
   rwf_station stn (.clk_in(clk_in), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
      .rx_sof_out(rx_sof), .rx_eof_out(rx_eof), .rx_crc_err_out(rx_crc),
      .rx_delimiter_error_flag_out(rx_sfd));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_in);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      @(posedge clk_in);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_in);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, e);
   endtask
   // Frame, then wake length, interrupt, flags and interrupt clear
   task automatic frame(input rwf_bq_t q, input logic bad, input logic [15:0] ef,
      input int ew, input logic ei);
      int n;
      n = 0;
      stn.send(q, bad);
      #1;
      while (wake === 1'b1 && n < 100) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      chk(16'(n), 16'(ew));
      chk({15'h0, irq}, {15'h0, ei});
      rd(9'h135, ef);
      rd(9'h135, 16'h0000);
      wr(9'h152, 16'hffff);
      @(posedge clk_in);
      #1;
      chk({15'h0, irq}, 16'h0000);
      $display("frame test done, flags %h", ef);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Hang guard, far above the expected run length
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(9'h134, 16'h1000);
      rd(9'h135, 16'h0000);
      chk({15'h0, wake}, 16'h0000);
      rd(9'h100, 16'h0000);
      wr(9'h136, 16'h2211);
      wr(9'h137, 16'h4433);
      wr(9'h138, 16'h6655);
      rd(9'h138, 16'h6655);
      wr(9'h13c, 16'hbbaa);
      wr(9'h153, 16'h0017);
      wr(9'h134, 16'h0897);
      rd(9'h134, 16'h0097);
      $display("register test done");
      frame('{8'haa, 8'hbb, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, 16'h0002, 8, 1'b1);
      wr(9'h150, 16'h0001);
      frame('{8'hcc, 8'hbb, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, 16'h0002, 8, 1'b1);
      repeat (6) mg.push_back(8'hff);
      for (int i = 0; i < 96; i++) mg.push_back(uc[i % 6]);
      frame(mg, 1'b0, 16'h0001, 8, 1'b1);
      wr(9'h139, 16'h0807);
      wr(9'h13a, 16'h0a09);
      wr(9'h13b, 16'h0c0b);
      frame(mg, 1'b0, 16'h0000, 0, 1'b0);
      for (int i = 7; i < 13; i++) mg.push_back(8'(i));
      frame(mg, 1'b0, 16'h0001, 8, 1'b1);
      frame(uc, 1'b1, 16'h0040, 0, 1'b0);
      for (int s = 0; s < 4; s++) begin
         wr(9'h134, 16'h0097 | 16'(s << 9));
         frame(uc, 1'b0, 16'h0010, 8 << s, 1'b1);
      end
      wr(9'h134, 16'h0197);
      frame(uc, 1'b0, 16'h0010, 100, 1'b1);
      wr(9'h134, 16'h0997);
      #1;
      chk({15'h0, wake}, 16'h0000);
      wr(9'h134, 16'h0097);
      wr(9'h153, 16'h0000);
      frame('{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00}, 1'b0, 16'h0004, 8, 1'b0);
      wr(9'h134, 16'h0017);
      frame(uc, 1'b0, 16'h0000, 0, 1'b0);
      wr(9'h134, 16'h0097);
      stn.sfd();
      @(posedge clk_in);
      addr <= 9'h135;
      rd_en <= 1'b1;
      @(posedge clk_in);
      #1;
      chk(rd_data, 16'h0080);
      @(posedge clk_in);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, 16'h0000);
      $display("delimiter test done");
      test_done();
   end
endmodule
